/* verilog/adc_output_formatter.v */
// Purpose: Gain, noise shaping, formatting and DDR lane mux
// Assumes: Core samples arrive every second core clock
// Notes: Output clock runs at half the core clock rate
//
// What this block does
// [RL1] Noise shaping offers 90 or 45 bands
// [RL2] 45 selection notches low and high together
// [RL3] Per-channel gain 0 to 6 dB, 0.5 steps
// [RL4] Gain inactive after reset until enabled
// [RL5] Enable activates all four gains at 0 dB
// [RL6] Controller writes gain after enabling digital
// [RL7] 11-bit samples, 14-bit in burst mode
// [RL8] Pair shares lanes, one clock per pair
// [RL9] Lanes interleave pair channels, double data rate
// [RL10] Samples are twos complement
// [RL11] Positive overdrive gives code 3ff
// [RL12] Negative overdrive gives code 400
// [RL13] High-resolution flag high during 14-bit output
// [RL14] Lane 0 carries overrange, or burst LSB
// [RL15] First channel rising, second channel falling
// [RL16] Gain code counts half-dB, above 12 clamps
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fmt_defs.vh"
module adc_output_formatter (
    input wire I_CORE_CLK, // Core clock, 40 MHz
    input wire I_RST_N, // Async reset, active low
    input wire I_CE, // Clock enable, freezes all state
    input wire I_PSEL, // APB select
    input wire I_PENABLE, // APB enable
    input wire I_PWRITE, // APB write
    input wire [7:0] I_PADDR, // APB byte address
    input wire [31:0] I_PWDATA, // APB write data
    output wire [31:0] O_PRDATA, // APB read data
    output wire O_PREADY, // APB ready
    output wire O_PSLVERR, // APB error on unmapped address
    input wire [13:0] I_SMP_A, // Channel A raw sample
    input wire [13:0] I_SMP_B, // Channel B raw sample
    input wire [13:0] I_SMP_C, // Channel C raw sample
    input wire [13:0] I_SMP_D, // Channel D raw sample
    input wire [3:0] I_OVR, // Input overdrive per channel
    input wire I_TRIG, // Burst trigger pin
    output reg [13:0] O_AB_LANE_P, // Pair AB lanes, positive
    output reg [13:0] O_AB_LANE_N, // Pair AB lanes, negative
    output reg [13:0] O_CD_LANE_P, // Pair CD lanes, positive
    output reg [13:0] O_CD_LANE_N, // Pair CD lanes, negative
    output reg O_AB_CLK_P, // Pair AB output clock, positive
    output reg O_AB_CLK_N, // Pair AB output clock, negative
    output reg O_CD_CLK_P, // Pair CD output clock, positive
    output reg O_CD_CLK_N, // Pair CD output clock, negative
    output reg O_HIGH_RESOLUTION_FLAG_AB, // Pair AB sends 14-bit data
    output reg O_HIGH_RESOLUTION_FLAG_CD, // Pair CD sends 14-bit data
    output reg O_TRIG_READY // Waiting for a trigger edge
);
    localparam ST_IDLE = 2'b00;
    localparam ST_HI = 2'b01;
    localparam ST_LO = 2'b10;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // [RL16] Half-dB code to Q12 factor
    // [RL3] Thirteen codes, twelve half-dB steps, up to 6 dB
    function [13:0] gain_mult;
        input [3:0] code;
        begin
            case ((code > `GAIN_MAX) ? `GAIN_MAX : code)
                4'h0: gain_mult = 14'h1000;
                4'h1: gain_mult = 14'h10f3;
                4'h2: gain_mult = 14'h11f4;
                4'h3: gain_mult = 14'h1304;
                4'h4: gain_mult = 14'h1425;
                4'h5: gain_mult = 14'h1556;
                4'h6: gain_mult = 14'h169a;
                4'h7: gain_mult = 14'h17f1;
                4'h8: gain_mult = 14'h195c;
                4'h9: gain_mult = 14'h1adc;
                4'ha: gain_mult = 14'h1c74;
                4'hb: gain_mult = 14'h1e23;
                // Rounded to the nearest step, so each code stays on the half-dB grid
                default: gain_mult = 14'h1fed;
            endcase
        end
    endfunction

    // [RL11] [RL12] Clamp to 14-bit full scale
    function [13:0] sat14;
        input [16:0] v;
        begin
            if (!v[16] && (v > `POS_FULL17))
                sat14 = `POS_FULL14;
            else if (v[16] && (v < `NEG_FULL17))
                sat14 = `NEG_FULL14;
            else
                sat14 = v[13:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------
    reg [`CTRL_W-1:0] ctrl_r;
    reg [15:0] gain_r;
    reg [15:0] hi_len_r;
    reg [15:0] lo_len_r;
    reg [31:0] prdata_r;
    reg [1:0] st_r;
    wire wr_en = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
    wire mapped = (I_PADDR == `ADDR_CTRL) | (I_PADDR == `ADDR_GAIN) |
                  (I_PADDR == `ADDR_BURST) | (I_PADDR == `ADDR_STAT);
    // No wait states except while the block is frozen
    assign O_PREADY = I_CE;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
    assign O_PRDATA = prdata_r;
    wire dig_en = ctrl_r[`CTRL_DIGEN];
    wire band45 = ctrl_r[`CTRL_BAND45];

    // Register writes; gain stays off until software enables it
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r <= `CTRL_RST;
            gain_r <= `GAIN_RST;
            hi_len_r <= `HI_LEN_RST;
            lo_len_r <= `LO_LEN_RST;
        end else if (wr_en) begin
            case (I_PADDR)
                `ADDR_CTRL: begin
                    ctrl_r <= I_PWDATA[`CTRL_W-1:0];
                    // [RL5] Enable restarts at 0 dB
                    // A gain written while disabled would otherwise act at once
                    if (!dig_en && I_PWDATA[`CTRL_DIGEN])
                        gain_r <= `GAIN_RST;
                end
                `ADDR_GAIN: gain_r <= I_PWDATA[15:0];
                `ADDR_BURST: begin
                    hi_len_r <= I_PWDATA[15:0];
                    lo_len_r <= I_PWDATA[31:16];
                end
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle, stable in access
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            prdata_r <= 32'h0;
        end else if (I_CE && I_PSEL && !I_PENABLE) begin
            case (I_PADDR)
                `ADDR_CTRL: prdata_r <= {26'h0, ctrl_r};
                `ADDR_GAIN: prdata_r <= {16'h0, gain_r};
                `ADDR_BURST: prdata_r <= {lo_len_r, hi_len_r};
                `ADDR_STAT: prdata_r <= {27'h0, O_TRIG_READY, O_HIGH_RESOLUTION_FLAG_CD,
                                         O_HIGH_RESOLUTION_FLAG_AB, st_r};
                default: prdata_r <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trigger pin synchroniser and burst sequencer
    // ------------------------------------------------------------
    reg trig_s1_r;
    reg trig_s2_r;
    reg trig_s3_r;
    reg trig_pend_r;
    reg ph_r;
    reg [15:0] cnt_r;
    wire cap = I_CE & ~ph_r;
    wire [1:0] burst_en = {ctrl_r[`CTRL_BURST_CD], ctrl_r[`CTRL_BURST_AB]};
    wire trig_rise = trig_s2_r & ~trig_s3_r;
    wire consume = cap & (st_r == ST_IDLE);
    // [RL13] Pair is in 14-bit output only while in the burst
    wire [1:0] high_resolution_flag_now = burst_en & {2{st_r == ST_HI}};

    // Two stages before the edge detector reads the pin
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
            trig_pend_r <= 1'b0;
        end else if (I_CE) begin
            trig_s1_r <= I_TRIG;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
            // A new edge wins over the consuming clear
            trig_pend_r <= trig_rise | (trig_pend_r & ~consume);
        end
    end

    // [RL7] Burst sequencer: high-res run, then low-res run
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r <= ST_IDLE;
            cnt_r <= 16'h0;
        end else if (cap) begin
            if (burst_en == 2'b00) begin
                st_r <= ST_IDLE;
            end else begin
                case (st_r)
                    ST_IDLE: if (trig_pend_r) begin
                        st_r <= ST_HI;
                        cnt_r <= hi_len_r - 16'h1;
                    end
                    ST_HI: if (cnt_r == 16'h0) begin
                        st_r <= ST_LO;
                        cnt_r <= lo_len_r - 16'h1;
                    end else begin
                        cnt_r <= cnt_r - 16'h1;
                    end
                    ST_LO: if (cnt_r == 16'h0) begin
                        // Auto mode repeats without a further edge
                        st_r <= ctrl_r[`CTRL_AUTO] ? ST_HI : ST_IDLE;
                        cnt_r <= hi_len_r - 16'h1;
                    end else begin
                        cnt_r <= cnt_r - 16'h1;
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Per-channel gain, noise shaping and formatting
    // ------------------------------------------------------------
    wire [55:0] smp_all = {I_SMP_D, I_SMP_C, I_SMP_B, I_SMP_A};
    reg [1:0] high_resolution_flag_q_r;
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_ch
            reg [13:0] word_r;
            reg [15:0] err_r;
            wire [13:0] x = smp_all[14*c+13:14*c];
            // [RL4] [RL5] Unity unless digital functions enabled
            wire [13:0] mul = dig_en ? gain_mult(gain_r[4*c+3:4*c]) : `GAIN_UNITY;
            wire signed [28:0] prod = $signed(x) * $signed({1'b0, mul});
            // [RL10] Signed product kept twos complement
            wire [13:0] w = sat14(prod[28:`GAIN_SHIFT]);
            wire clip = (w == `POS_FULL14) | (w == `NEG_FULL14);
            wire hi = high_resolution_flag_now[c/2];
            wire ns_on = ctrl_r[`CTRL_NSEN] & ~hi;
            // [RL1] [RL2] Error fed back two or four samples late
            wire [3:0] fb = band45 ? err_r[15:12] : err_r[7:4];
            wire [16:0] sum = {{3{w[13]}}, w} + {{13{fb[3]}}, fb};
            wire [13:0] v = ns_on ? sat14(sum) : w;
            wire [3:0] q = 4'h0 - {1'b0, v[2:0]};
            // [RL14] Lane 0 is overrange, or LSB in a burst
            wire ovr = I_OVR[c] | clip;
            wire [13:0] word = hi ? w : {v[13:3], 2'b00, ovr};

            // Word and shaping error taken once per sample
            always @(posedge I_CORE_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    word_r <= 14'h0;
                    err_r <= 16'h0;
                end else if (cap) begin
                    word_r <= word;
                    err_r <= ns_on ? {err_r[11:0], q} : 16'h0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // DDR lane multiplexer and output clocks
    // ------------------------------------------------------------
    // [RL8] [RL9] [RL15] Pair shares lanes, A or C with clock high
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ph_r <= 1'b0;
            high_resolution_flag_q_r <= 2'b00;
            O_AB_LANE_P <= 14'h0;
            O_AB_LANE_N <= 14'h3fff;
            O_CD_LANE_P <= 14'h0;
            O_CD_LANE_N <= 14'h3fff;
            O_AB_CLK_P <= 1'b0;
            O_AB_CLK_N <= 1'b1;
            O_CD_CLK_P <= 1'b0;
            O_CD_CLK_N <= 1'b1;
            O_HIGH_RESOLUTION_FLAG_AB <= 1'b0;
            O_HIGH_RESOLUTION_FLAG_CD <= 1'b0;
            O_TRIG_READY <= 1'b0;
        end else if (I_CE) begin
            ph_r <= ~ph_r;
            if (cap)
                high_resolution_flag_q_r <= high_resolution_flag_now;
            O_AB_CLK_P <= ph_r;
            O_AB_CLK_N <= ~ph_r;
            O_CD_CLK_P <= ph_r;
            O_CD_CLK_N <= ~ph_r;
            O_AB_LANE_P <= ph_r ? g_ch[0].word_r : g_ch[1].word_r;
            O_AB_LANE_N <= ph_r ? ~g_ch[0].word_r : ~g_ch[1].word_r;
            O_CD_LANE_P <= ph_r ? g_ch[2].word_r : g_ch[3].word_r;
            O_CD_LANE_N <= ph_r ? ~g_ch[2].word_r : ~g_ch[3].word_r;
            // [RL13] Flag follows the words on the lanes
            if (ph_r) begin
                O_HIGH_RESOLUTION_FLAG_AB <= high_resolution_flag_q_r[0];
                O_HIGH_RESOLUTION_FLAG_CD <= high_resolution_flag_q_r[1];
            end
            O_TRIG_READY <= (burst_en != 2'b00) & (st_r == ST_IDLE);
        end
    end
endmodule // adc_output_formatter
`default_nettype wire

/* shared/fmt_defs.vh */
// Purpose: Constants for the converter output formatter
// Assumes: APB byte addresses, 32-bit words
// Notes: Definitions only
`ifndef FMT_DEFS_VH
`define FMT_DEFS_VH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_GAIN 8'h04
`define ADDR_BURST 8'h08
`define ADDR_STAT 8'h0c
// Control bit positions
`define CTRL_DIGEN 0
`define CTRL_NSEN 1
`define CTRL_BAND45 2
`define CTRL_BURST_AB 3
`define CTRL_BURST_CD 4
`define CTRL_AUTO 5
`define CTRL_W 6
`define CTRL_RST 6'h00
`define GAIN_RST 16'h0000
// Burst lengths in samples
`define HI_LEN_RST 16'h0400
`define LO_LEN_RST 16'h2000
// ------------------------------------------------------------
// Data path
// ------------------------------------------------------------
`define GAIN_MAX 4'hc
`define GAIN_UNITY 14'h1000
`define GAIN_SHIFT 12
`define POS_FULL14 14'h1fff
`define NEG_FULL14 14'h2000
`define POS_FULL17 17'h01fff
`define NEG_FULL17 17'h1e000
`endif

/* tb/fmt_asserts.sv */
// Purpose: Port checks for the output formatter
// Assumes: One core clock domain, reset active low
// Notes: Bound to every formatter instance
`timescale 1ns/10ps
`default_nettype none
module fmt_asserts (
    input wire I_CORE_CLK, // Core clock
    input wire I_RST_N, // Reset, active low
    input wire I_CE, // Clock enable
    input wire [13:0] O_AB_LANE_P, // Pair AB lanes
    input wire [13:0] O_AB_LANE_N, // Pair AB lanes, inverse
    input wire [13:0] O_CD_LANE_P, // Pair CD lanes
    input wire [13:0] O_CD_LANE_N, // Pair CD lanes, inverse
    input wire O_AB_CLK_P, // Pair AB clock
    input wire O_AB_CLK_N, // Pair AB clock, inverse
    input wire O_CD_CLK_P, // Pair CD clock
    input wire O_CD_CLK_N, // Pair CD clock, inverse
    input wire O_HIGH_RESOLUTION_FLAG_AB, // Pair AB 14-bit flag
    input wire O_HIGH_RESOLUTION_FLAG_CD // Pair CD 14-bit flag
);
    // ------------------------------------------------------------
    // Lane and clock relations
    // ------------------------------------------------------------
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    property p_clk_fall; I_CE && O_AB_CLK_P |=> !O_AB_CLK_P; endproperty
    a_clk_fall: assert property (p_clk_fall) else $error("pair clock stuck high");
    property p_clk_rise; I_CE && !O_AB_CLK_P && $past(O_AB_CLK_P) |=> O_AB_CLK_P; endproperty
    a_clk_rise: assert property (p_clk_rise) else $error("pair clock stuck low");
    property p_clk_inv; O_AB_CLK_N == !O_AB_CLK_P && O_CD_CLK_N == !O_CD_CLK_P; endproperty
    a_clk_inv: assert property (p_clk_inv) else $error("output clock legs equal");
    property p_lane_inv; O_AB_LANE_N == ~O_AB_LANE_P && O_CD_LANE_N == ~O_CD_LANE_P; endproperty
    a_lane_inv: assert property (p_lane_inv) else $error("lane legs not inverse");
    // Both pairs share one phase, so the receiver may use either clock
    property p_pair_align; O_CD_CLK_P == O_AB_CLK_P; endproperty
    a_pair_align: assert property (p_pair_align) else $error("pair clocks apart");
    property p_ab_pad; !O_HIGH_RESOLUTION_FLAG_AB |-> O_AB_LANE_P[2:1] == 2'b00; endproperty
    a_ab_pad: assert property (p_ab_pad) else $error("AB 11-bit word padding");
    property p_cd_pad; !O_HIGH_RESOLUTION_FLAG_CD |-> O_CD_LANE_P[2:1] == 2'b00; endproperty
    a_cd_pad: assert property (p_cd_pad) else $error("CD 11-bit word padding");
    property p_high_resolution_flag_hold; I_CE && O_AB_CLK_P |=> $stable(O_HIGH_RESOLUTION_FLAG_AB); endproperty
    a_high_resolution_flag_hold: assert property (p_high_resolution_flag_hold) else $error("flag moved mid pair");
endmodule // fmt_asserts
bind adc_output_formatter fmt_asserts chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
    .I_CE(I_CE), .O_AB_LANE_P(O_AB_LANE_P), .O_AB_LANE_N(O_AB_LANE_N),
    .O_CD_LANE_P(O_CD_LANE_P), .O_CD_LANE_N(O_CD_LANE_N), .O_AB_CLK_P(O_AB_CLK_P),
    .O_AB_CLK_N(O_AB_CLK_N), .O_CD_CLK_P(O_CD_CLK_P), .O_CD_CLK_N(O_CD_CLK_N),
    .O_HIGH_RESOLUTION_FLAG_AB(O_HIGH_RESOLUTION_FLAG_AB), .O_HIGH_RESOLUTION_FLAG_CD(O_HIGH_RESOLUTION_FLAG_CD));
`default_nettype wire

/* tb/fmt_rx_model.sv */
// Purpose: Receiving logic for one lane pair
// Assumes: Pair clock sampled by the core clock
// Notes: Sees levels only, like an oversampling receiver
`timescale 1ns/10ps
`default_nettype none
module fmt_rx_model (
    input wire logic i_clk, // Core clock
    input wire logic i_clk_p, // Pair output clock
    input wire logic [13:0] i_lane, // Pair lanes, positive
    input wire logic i_high_resolution_flag, // Pair 14-bit flag
    output logic [13:0] o_first, // Word of the high half
    output logic [13:0] o_second, // Word of the low half
    output logic o_hi, // Pair came as 14-bit
    output logic o_got // One cycle when a pair is complete
);
    logic prev_r;
    // High half gives the first channel, the following low half the second
    always @(posedge i_clk) begin
        prev_r <= i_clk_p;
        o_got <= 1'b0;
        if (i_clk_p) begin
            o_first <= i_lane;
            o_hi <= i_high_resolution_flag;
        end else if (prev_r) begin
            o_second <= i_lane;
            o_got <= 1'b1;
        end
    end
endmodule // fmt_rx_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the output formatter
// Assumes: Zero-wait APB while clock enable is high
// Notes: Expected words are computed here, gain in real maths
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rst_n, ce, psel, pen, pwr, trig, perr, rdy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [13:0] sa, sb, sc, sd, abp, abn, cdp, cdn, w1, w2, w3, w4;
    logic [3:0] ovr;
    logic abk, abkn, cdk, cdkn, hab, hcd, trdy, got, hi, got2, hi2;
    int failures, compares, seed, n, m, k;
    // Core clock, 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    adc_output_formatter dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(rdy), .O_PSLVERR(perr), .I_SMP_A(sa), .I_SMP_B(sb), .I_SMP_C(sc),
        .I_SMP_D(sd), .I_OVR(ovr), .I_TRIG(trig), .O_AB_LANE_P(abp), .O_AB_LANE_N(abn),
        .O_CD_LANE_P(cdp), .O_CD_LANE_N(cdn), .O_AB_CLK_P(abk), .O_AB_CLK_N(abkn),
        .O_CD_CLK_P(cdk), .O_CD_CLK_N(cdkn), .O_HIGH_RESOLUTION_FLAG_AB(hab), .O_HIGH_RESOLUTION_FLAG_CD(hcd),
        .O_TRIG_READY(trdy));
    fmt_rx_model rx_u (.i_clk(clk), .i_clk_p(abk), .i_lane(abp), .i_high_resolution_flag(hab),
        .o_first(w1), .o_second(w2), .o_hi(hi), .o_got(got));
    fmt_rx_model rx2_u (.i_clk(clk), .i_clk_p(cdk), .i_lane(cdp), .i_high_resolution_flag(hcd),
        .o_first(w3), .o_second(w4), .o_hi(hi2), .o_got(got2));
    // Lane word for gain code k: Q12 factor, 11 MSBs; a full-scale 14-bit value flags overrange
    function automatic logic [13:0] gw(input logic [13:0] s, input int k, input logic o);
        int v;
        v = ($signed(s) * $rtoi(4096.0 * 10.0 ** ((k > 12 ? 12 : k) / 40.0) + 0.5)) >>> 12;
        if (v >= 8191) return {11'h3ff, 3'h1};
        if (v <= -8192) return {11'h400, 3'h1};
        return {v[13:3], 2'b00, o};
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // One APB transfer; result left in q and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Hold a sample pair long enough to cross the lanes, then compare both halves
    task automatic pair(input logic [13:0] a, input logic [13:0] b, input int ka, input int kb);
        sa <= a;
        sb <= b;
        repeat (6) @(posedge clk);
        check(w1, gw(a, ka, ovr[0]));
        check(w2, gw(b, kb, ovr[1]));
        // Channels C and D always run at 0 dB in these scenarios
        check(w3, gw(sc, 0, ovr[2]));
        check(w4, gw(sd, 0, ovr[3]));
    endtask
    task automatic conclude();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected run of under 2000 cycles
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        seed = 32'h606e;
        {rst_n, ce, psel, pen, pwr, trig} = 6'b010000;
        {paddr, pwdata, ovr, sa, sb, sc, sd} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        check(q, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({q[30:0], e}, 32'h1);
        // A gain written while disabled must not act, nor survive the enable
        apb(1'b1, 8'h04, 32'h00fc);
        pair(14'h0400, 14'h0400, 0, 0);
        apb(1'b1, 8'h00, 32'h1);
        pair(14'h0400, 14'h0400, 0, 0);
        // Enable first, then program the fields
        apb(1'b1, 8'h04, 32'h00fc);
        pair(14'h0400, 14'h0400, 12, 15);
        pair(14'h1fff, 14'h2000, 12, 15);
        apb(1'b1, 8'h00, 32'h0);
        pair(14'h0400, 14'h0400, 0, 0);
        // Random traffic, with a clock-enable stall in the middle
        for (n = 0; n < 24; n++) begin
            ovr <= $random(seed);
            sc <= $random(seed);
            sd <= $random(seed);
            if (n == 9) begin
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
            pair($random(seed), $random(seed), 0, 0);
        end
        ovr <= 4'h0;
        // Shaping subtracts at most the dropped bits, so the word is the truncation or one below
        for (n = 2; n < 8; n += 4) begin
            apb(1'b1, 8'h00, n);
            sa <= 14'h0403;
            repeat (6) @(posedge clk);
            check(w1[13:3] == 11'h07f || w1[13:3] == 11'h080, 1'b1);
        end
        // Burst on both pairs, manual then auto: four 14-bit samples, eight 11-bit
        apb(1'b1, 8'h08, {16'd8, 16'd4});
        for (m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'h38 : 32'h18);
            repeat (4) @(posedge clk);
            check(trdy, 1'b1);
            sa <= 14'h1235;
            sc <= 14'h0ace;
            trig <= 1'b1;
            repeat (4) @(posedge clk);
            trig <= 1'b0;
            n = 0;
            k = -1;
            repeat (80) begin
                @(posedge clk);
                // k counts samples from the first 14-bit one; sample 12 restarts only in auto
                if (got && (hi || k >= 0)) k++;
                if (got && k == 12) check(hi, m);
                if (got && hi && k < 4) begin
                    n++;
                    check(w1, 14'h1235);
                end
                if (got2 && hi2 && k < 4) begin
                    n++;
                    check(w3, 14'h0ace);
                end
            end
            check(n, 8);
        end
        conclude();
    end
endmodule // testbench
`default_nettype wire
